/* logic/plcs_regs.vh */
/*
 Register map, field layout, reset values and timing constants
 of the peer link configuration and status bank.
 Assumes a 100 MHz APB clock and byte addresses on paddr.
*/
`ifndef PLCS_REGS_VH
`define PLCS_REGS_VH

// Register byte offsets
`define PLCS_OFF_STATION 8'h00
`define PLCS_OFF_SLAVES 8'h04
`define PLCS_OFF_PATTERN 8'h08
`define PLCS_OFF_RETRY 8'h0C
`define PLCS_OFF_TIMEOUT 8'h10
`define PLCS_OFF_CYC_NOW 8'h14
`define PLCS_OFF_CYC_PEAK 8'h18
`define PLCS_OFF_AREA 8'h1C
`define PLCS_OFF_ABNORMAL 8'h20
`define PLCS_OFF_LAST_ERR 8'h24
`define PLCS_OFF_ERRCNT 8'h40
`define PLCS_OFF_ERRCNT_END 8'h5C

// Reset values
`define PLCS_RST_STATION 3'h0
`define PLCS_RST_SLAVES 3'h7
`define PLCS_RST_PATTERN 2'h0
`define PLCS_RST_RETRY 4'h3
`define PLCS_RST_TIMEOUT 8'h05

// Legal ranges
`define PLCS_STATION_MAX 3'h7
`define PLCS_SLAVES_MIN 3'h1
`define PLCS_PATTERN_MAX 2'h2
`define PLCS_RETRY_MAX 4'hA
`define PLCS_TIMEOUT_MIN 8'h05

// Link area layout
`define PLCS_BIT_HEAD 11'h3E8
`define PLCS_BIT_STRIDE 7'h40
`define PLCS_WORD_STRIDE 4'hA

// Error codes
`define PLCS_ERR_SLAVE_SILENT 8'h01
`define PLCS_ERR_MASTER_SILENT 8'h11

// Timing: one status unit in ms, clock rate in MHz
`define PLCS_UNIT_MS 10
`define PLCS_CLK_MHZ 100
`define PLCS_TICK_CYCLES (`PLCS_UNIT_MS * 1000 * `PLCS_CLK_MHZ)

`endif

/* logic/plcs_link_regs.v */
/*
 Configuration and supervision register bank of a multi-drop
 controller link: settings, link areas, cycle time, error counts.
 Assumes an APB master on pclk and a link engine that pulses
 cycle_done, xfer_req and xfer_resp synchronous to pclk.
*/
`timescale 1ns/10ps
`include "plcs_regs.vh"

module plcs_link_regs #(
    parameter TICK_CYCLES = `PLCS_TICK_CYCLES,
    parameter TICK_W = 20,
    parameter CNT_W = 16
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire cycle_done,
    input wire xfer_req,
    input wire [2:0] xfer_station,
    input wire xfer_resp,
    input wire [2:0] resp_station,
    output reg [2:0] own_station_number,
    output reg [2:0] slave_count_setting,
    output reg [1:0] refresh_pattern_setting,
    output reg [3:0] retry_count_setting,
    output reg [7:0] response_timeout_setting,
    output reg is_master,
    output reg [6:0] area_bit_count,
    output reg [3:0] area_word_count,
    output reg [10:0] area_bit_base,
    output reg [6:0] area_word_base,
    output reg retry_req,
    output reg seq_error,
    output reg [2:0] seq_error_station
);

localparam [1:0] ST_IDLE = 2'b01;
localparam [1:0] ST_WAIT = 2'b10;
localparam [31:0] TICK_LAST_W = TICK_CYCLES - 1;
localparam [TICK_W-1:0] TICK_LAST = TICK_LAST_W[TICK_W-1:0];

// Bits owned per station for a pattern
function [6:0] pat_bits;
    input [1:0] pat;
    begin
        case (pat)
            2'h1: pat_bits = 7'h20;
            2'h2: pat_bits = 7'h40;
            default: pat_bits = 7'h00;
        endcase
    end
endfunction

// Words owned per station for a pattern
function [3:0] pat_words;
    input [1:0] pat;
    begin
        pat_words = (pat == 2'h2) ? 4'h8 : 4'h4;
    end
endfunction

reg [15:0] cycle_time_now_reg;
reg [15:0] cycle_time_peak_reg;
reg [15:0] cyc_ticks_reg;
reg [TICK_W-1:0] cyc_pre_reg;
reg [TICK_W-1:0] xfer_pre_reg;
reg [7:0] xfer_ticks_reg;
reg [3:0] retries_reg;
reg [2:0] target_reg;
reg [1:0] state_reg;
reg [7:0] abnormal_reg;
reg [2:0] last_err_station_reg;
reg [7:0] last_err_code_reg;
wire [CNT_W-1:0] err_cnt [0:7];
wire timeout_hit;
wire give_up;

////////////////////////////////////////////////////////////////////
// APB decode

wire setup = psel & ~penable;
wire wr_go = psel & penable & pwrite;
wire [31:0] wd = pwdata;
wire in_cnt = (paddr >= `PLCS_OFF_ERRCNT) && (paddr <= `PLCS_OFF_ERRCNT_END);
wire [2:0] cnt_idx = paddr[4:2];

// Value legality of a write
reg wr_ok;
reg mapped;
always @*
begin
    mapped = 1'b1;
    wr_ok = 1'b0;
    case (paddr)
        `PLCS_OFF_STATION: wr_ok = wd[15:0] <= {13'h0000, `PLCS_STATION_MAX};
        `PLCS_OFF_SLAVES: wr_ok = (wd[15:0] >= {13'h0000, `PLCS_SLAVES_MIN})
            && (wd[15:0] <= 16'h0007);
        `PLCS_OFF_PATTERN: wr_ok = wd[15:0] <= {14'h0000, `PLCS_PATTERN_MAX};
        `PLCS_OFF_RETRY: wr_ok = wd[15:0] <= {12'h000, `PLCS_RETRY_MAX};
        `PLCS_OFF_TIMEOUT: wr_ok = (wd[15:0] >= {8'h00, `PLCS_TIMEOUT_MIN})
            && (wd[15:0] <= 16'h00FF);
        `PLCS_OFF_ABNORMAL: wr_ok = 1'b1;
        `PLCS_OFF_CYC_NOW, `PLCS_OFF_CYC_PEAK, `PLCS_OFF_AREA,
        `PLCS_OFF_LAST_ERR: wr_ok = 1'b0;
        default:
        begin
            mapped = in_cnt;
            wr_ok = 1'b0;
        end
    endcase
end

// Zero wait states; refused writes and holes answer with an error
assign pready = 1'b1;
assign pslverr = psel & penable & (~mapped | (pwrite & ~wr_ok));

wire wr_take = wr_go & wr_ok;

// Read data captured in the setup cycle
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
        prdata <= 32'h00000000;
    else if (setup & ~pwrite)
    begin
        case (paddr)
            `PLCS_OFF_STATION: prdata <= {29'h0, own_station_number};
            `PLCS_OFF_SLAVES: prdata <= {29'h0, slave_count_setting};
            `PLCS_OFF_PATTERN: prdata <= {30'h0, refresh_pattern_setting};
            `PLCS_OFF_RETRY: prdata <= {28'h0, retry_count_setting};
            `PLCS_OFF_TIMEOUT: prdata <= {24'h0, response_timeout_setting};
            `PLCS_OFF_CYC_NOW: prdata <= {16'h0, cycle_time_now_reg};
            `PLCS_OFF_CYC_PEAK: prdata <= {16'h0, cycle_time_peak_reg};
            `PLCS_OFF_AREA: prdata <= {1'b0, area_word_base, area_bit_base,
                area_word_count, 2'b00, area_bit_count};
            `PLCS_OFF_ABNORMAL: prdata <= {24'h0, abnormal_reg};
            `PLCS_OFF_LAST_ERR: prdata <= {21'h0, last_err_station_reg,
                last_err_code_reg};
            default: prdata <= in_cnt ? {{(32-CNT_W){1'b0}}, err_cnt[cnt_idx]}
                : 32'h00000000;
        endcase
    end
end

////////////////////////////////////////////////////////////////////
// Settings

always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        own_station_number <= `PLCS_RST_STATION;
        slave_count_setting <= `PLCS_RST_SLAVES;
        refresh_pattern_setting <= `PLCS_RST_PATTERN;
        retry_count_setting <= `PLCS_RST_RETRY;
        response_timeout_setting <= `PLCS_RST_TIMEOUT;
    end
    else if (wr_take)
    begin
        case (paddr)
            `PLCS_OFF_STATION: own_station_number <= wd[2:0];
            `PLCS_OFF_SLAVES: slave_count_setting <= wd[2:0];
            `PLCS_OFF_PATTERN: refresh_pattern_setting <= wd[1:0];
            `PLCS_OFF_RETRY: retry_count_setting <= wd[3:0];
            `PLCS_OFF_TIMEOUT: response_timeout_setting <= wd[7:0];
            default: own_station_number <= own_station_number;
        endcase
    end
end

// Role and own link area from the settings
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        is_master <= 1'b1;
        area_bit_count <= 7'h00;
        area_word_count <= 4'h4;
        area_bit_base <= `PLCS_BIT_HEAD;
        area_word_base <= 7'h00;
    end
    else
    begin
        is_master <= (own_station_number == 3'h0);
        area_bit_count <= pat_bits(refresh_pattern_setting);
        area_word_count <= pat_words(refresh_pattern_setting);
        area_bit_base <= `PLCS_BIT_HEAD
            + {2'b00, own_station_number, 6'h00};
        area_word_base <= {4'h0, own_station_number} * {3'h0, `PLCS_WORD_STRIDE};
    end
end

////////////////////////////////////////////////////////////////////
// Link cycle time in 10 ms units

always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        cyc_pre_reg <= {TICK_W{1'b0}};
        cyc_ticks_reg <= 16'h0000;
        cycle_time_now_reg <= 16'h0000;
        cycle_time_peak_reg <= 16'h0000;
    end
    else if (cycle_done)
    begin
        cyc_pre_reg <= {TICK_W{1'b0}};
        cyc_ticks_reg <= 16'h0000;
        cycle_time_now_reg <= cyc_ticks_reg;
        if (cyc_ticks_reg > cycle_time_peak_reg)
            cycle_time_peak_reg <= cyc_ticks_reg;
    end
    else if (cyc_pre_reg == TICK_LAST)
    begin
        cyc_pre_reg <= {TICK_W{1'b0}};
        if (cyc_ticks_reg != 16'hFFFF)
            cyc_ticks_reg <= cyc_ticks_reg + 16'h0001;
    end
    else
        cyc_pre_reg <= cyc_pre_reg + {{(TICK_W-1){1'b0}}, 1'b1};
end

////////////////////////////////////////////////////////////////////
// Transfer supervision with retries

assign timeout_hit = (state_reg == ST_WAIT)
    && (xfer_ticks_reg >= response_timeout_setting);
assign give_up = timeout_hit && (retries_reg >= retry_count_setting);

always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        state_reg <= ST_IDLE;
        xfer_pre_reg <= {TICK_W{1'b0}};
        xfer_ticks_reg <= 8'h00;
        retries_reg <= 4'h0;
        target_reg <= 3'h0;
        retry_req <= 1'b0;
        seq_error <= 1'b0;
        seq_error_station <= 3'h0;
    end
    else
    begin
        retry_req <= 1'b0;
        seq_error <= 1'b0;
        case (state_reg)
            ST_IDLE:
            begin
                if (xfer_req && (xfer_station != own_station_number))
                begin
                    state_reg <= ST_WAIT;
                    target_reg <= xfer_station;
                    retries_reg <= 4'h0;
                    xfer_pre_reg <= {TICK_W{1'b0}};
                    xfer_ticks_reg <= 8'h00;
                end
            end
            ST_WAIT:
            begin
                if (xfer_resp && (resp_station == target_reg))
                    state_reg <= ST_IDLE;
                else if (give_up)
                begin
                    state_reg <= ST_IDLE;
                    seq_error <= 1'b1;
                    seq_error_station <= target_reg;
                end
                else if (timeout_hit)
                begin
                    retry_req <= 1'b1;
                    retries_reg <= retries_reg + 4'h1;
                    xfer_pre_reg <= {TICK_W{1'b0}};
                    xfer_ticks_reg <= 8'h00;
                end
                else if (xfer_pre_reg == TICK_LAST)
                begin
                    xfer_pre_reg <= {TICK_W{1'b0}};
                    xfer_ticks_reg <= xfer_ticks_reg + 8'h01;
                end
                else
                    xfer_pre_reg <= xfer_pre_reg + {{(TICK_W-1){1'b0}}, 1'b1};
            end
            default: state_reg <= ST_IDLE;
        endcase
    end
end

////////////////////////////////////////////////////////////////////
// Abnormal flags, last error code; set wins over write-one clear

wire err_now = (state_reg == ST_WAIT) & ~(xfer_resp & (resp_station == target_reg))
    & give_up;
wire [7:0] err_hot = err_now ? (8'h01 << target_reg) : 8'h00;
wire [7:0] clr_bits = (wr_take && (paddr == `PLCS_OFF_ABNORMAL)) ? wd[7:0] : 8'h00;

always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        abnormal_reg <= 8'h00;
        last_err_station_reg <= 3'h0;
        last_err_code_reg <= 8'h00;
    end
    else
    begin
        abnormal_reg <= (abnormal_reg & ~clr_bits) | err_hot;
        if (err_now)
        begin
            last_err_station_reg <= target_reg;
            last_err_code_reg <= is_master ? `PLCS_ERR_SLAVE_SILENT
                : `PLCS_ERR_MASTER_SILENT;
        end
    end
end

////////////////////////////////////////////////////////////////////
// Per-station sequence error counters, saturating

genvar gi;
generate
    for (gi = 0; gi < 8; gi = gi + 1)
    begin : g_cnt
        reg [CNT_W-1:0] cnt_reg;
        always @(posedge pclk or negedge presetn)
        begin
            if (!presetn)
                cnt_reg <= {CNT_W{1'b0}};
            else if (err_hot[gi] && (cnt_reg != {CNT_W{1'b1}}))
                cnt_reg <= cnt_reg + {{(CNT_W-1){1'b0}}, 1'b1};
        end
        assign err_cnt[gi] = cnt_reg;
    end
endgenerate

endmodule // plcs_link_regs

/* testbench/plcs_regs_chk_asserts.sv */
/*
 Port assertions of the peer link register bank.
 Assumes it is bound into plcs_link_regs: one clock, reset active low.
*/
`timescale 1ns/10ps
module plcs_regs_chk (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    input wire pslverr,
    input wire [2:0] own_station_number,
    input wire [2:0] slave_count_setting,
    input wire [1:0] refresh_pattern_setting,
    input wire [3:0] retry_count_setting,
    input wire [7:0] response_timeout_setting,
    input wire is_master,
    input wire [6:0] area_bit_count,
    input wire [3:0] area_word_count,
    input wire [10:0] area_bit_base,
    input wire [6:0] area_word_base,
    input wire retry_req,
    input wire seq_error
);
    //////////////////////////////////////////
    // One domain, checks off during reset
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire wr = psel && penable && pwrite;

    master_flag_a: assert property (
        is_master == ($past(own_station_number) == 3'h0)) else $error("master flag wrong");
    station_keep_a: assert property (
        wr && paddr == 8'h00 && pwdata > 32'h7 |-> pslverr ##1 $stable(own_station_number))
        else $error("bad station number taken");
    slave_keep_a: assert property (
        wr && paddr == 8'h04 && (pwdata == 32'h0 || pwdata > 32'h7)
        |-> pslverr ##1 $stable(slave_count_setting)) else $error("bad slave count taken");
    pattern_max_a: assert property (
        refresh_pattern_setting <= 2'h2) else $error("pattern out of range");
    area_count_a: assert property (
        area_word_count == (($past(refresh_pattern_setting) == 2'h2) ? 4'h8 : 4'h4)
        && area_bit_count == {$past(refresh_pattern_setting), 5'h00})
        else $error("area size wrong");
    area_base_a: assert property (
        area_bit_base == 11'h3E8 + {2'h0, $past(own_station_number), 6'h00}
        && area_word_base == {4'h0, $past(own_station_number)} * 7'hA)
        else $error("area base wrong");
    retry_max_a: assert property (
        retry_count_setting <= 4'hA) else $error("retry count out of range");
    timeout_min_a: assert property (
        response_timeout_setting >= 8'h05) else $error("timeout below minimum");
    seq_pulse_a: assert property (
        seq_error |-> !retry_req ##1 !seq_error) else $error("sequence error pulse wrong");
endmodule // plcs_regs_chk

bind plcs_link_regs plcs_regs_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pslverr, .own_station_number, .slave_count_setting, .refresh_pattern_setting,
    .retry_count_setting, .response_timeout_setting, .is_master, .area_bit_count,
    .area_word_count, .area_bit_base, .area_word_base, .retry_req, .seq_error);

/* testbench/plcs_link_peer.sv */
/*
 Link engine model: cycle ends, requests and station answers.
 Assumes its tasks are called just after a rising pclk edge.
*/
`timescale 1ns/10ps
module plcs_link_peer (
    input wire pclk,
    output logic cycle_done = 1'b0,
    output logic xfer_req = 1'b0,
    output wire [2:0] xfer_station,
    output logic xfer_resp = 1'b0,
    output wire [2:0] resp_station
);
    logic [2:0] junk = 3'h0;
    logic [2:0] tgt = 3'h0;
    //////////////////////////////////////////
    // Station fields wander while unqualified
    always @(posedge pclk)
        junk <= junk + 3'h3;
    assign xfer_station = xfer_req ? tgt : junk;
    assign resp_station = xfer_resp ? tgt : ~junk;
    // Request; dly 0 means silent station, peers keep off link areas
    task send(input logic [2:0] st, input int dly);
        tgt <= st;
        xfer_req <= 1'b1;
        @(posedge pclk);
        xfer_req <= 1'b0;
        if (dly > 0)
        begin
            repeat (dly - 1) @(posedge pclk);
            xfer_resp <= 1'b1;
            @(posedge pclk);
            xfer_resp <= 1'b0;
        end
    endtask
    // Link cycle end n cycles after the previous one
    task cyc(input int n);
        repeat (n - 1) @(posedge pclk);
        cycle_done <= 1'b1;
        @(posedge pclk);
        cycle_done <= 1'b0;
    endtask
endmodule // plcs_link_peer

/* testbench/tb.sv */
/*
 Self-checking bench of the peer link register bank.
 Assumes a tick shortened to 10 cycles and the link peer model.
*/
`timescale 1ns/10ps
module tb;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] sd = 32'h59DF;
    logic [31:0] prdata, rd, v;
    logic pready, pslverr, cycle_done, xfer_req, xfer_resp, is_master, retry_req, seq_error, er, ok;
    logic [2:0] xfer_station, resp_station, seq_error_station;
    int n_errors = 0;
    int comparisons = 0;
    int i, nr;
    int lo[5] = '{0, 1, 0, 0, 5};
    int hi[5] = '{7, 7, 2, 10, 255};
    logic [31:0] cur[7] = '{0, 7, 0, 3, 5, 0, 0};
    plcs_link_regs #(.TICK_CYCLES(10)) dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .cycle_done, .xfer_req, .xfer_station, .xfer_resp,
        .resp_station, .own_station_number(), .slave_count_setting(), .refresh_pattern_setting(),
        .retry_count_setting(), .response_timeout_setting(), .is_master, .area_bit_count(),
        .area_word_count(), .area_bit_base(), .area_word_base(), .retry_req, .seq_error,
        .seq_error_station);
    plcs_link_peer m (.pclk, .cycle_done, .xfer_req, .xfer_station, .xfer_resp, .resp_station);
    always #5 pclk = ~pclk;
    //////////////////////////////////////////
    // Helpers: compare, random, bus cycle, expected area word
    task ck(input string n, input logic [31:0] e, input logic [31:0] s);
        comparisons++;
        if (s !== e)
        begin
            n_errors++;
            $display("BAD %s expected %h seen %h", n, e, s);
        end
    endtask
    function logic [31:0] rnd();
        sd = {sd[30:0], sd[31] ^ sd[21] ^ sd[1] ^ sd[0]};
        return sd;
    endfunction
    function logic [31:0] area(int n, int p);
        return (n * 10) << 24 | (1000 + 64 * n) << 13 | (p == 2 ? 8 : 4) << 9 | p * 32;
    endfunction
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
        output logic e);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk); // Idle edge lets derived registers settle
    endtask
    task end_of_test;
        if (n_errors == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // Main sequence
    initial
    begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        for (int j = 0; j < 7; j++)
        begin
            apb(1'b0, 8'(j * 4), 0, rd, er);
            ck("reset value", cur[j], rd);
        end
        m.cyc(1);
        m.cyc(55);
        m.cyc(25);
        apb(1'b0, 8'h14, 0, rd, er);
        ck("cycle now", 2, rd);
        apb(1'b0, 8'h18, 0, rd, er);
        ck("cycle peak", 5, rd);
        apb(1'b1, 8'h14, 9, rd, er);
        ck("read only refusal", 1, er);
        for (int k = 0; k < 40; k++)
        begin
            i = k % 5;
            v = k < 5 ? hi[i] + 1 : k < 10 ? lo[i] - (lo[i] > 0) : rnd() % (hi[i] + 3);
            ok = v >= lo[i] && v <= hi[i];
            apb(1'b1, 8'(i * 4), v, rd, er);
            ck("refusal flag", !ok, er);
            if (ok)
                cur[i] = v;
            apb(1'b0, 8'(i * 4), 0, rd, er);
            ck("setting", cur[i], rd);
        end
        for (int n = 0; n < 8; n++)
            for (int p = 0; p < 3; p++)
            begin
                apb(1'b1, 8'h00, n, rd, er);
                apb(1'b1, 8'h08, p, rd, er);
                apb(1'b0, 8'h1C, 0, rd, er);
                ck("area", area(n, p), rd);
                ck("master flag", n == 0, is_master);
            end
        apb(1'b1, 8'h00, 0, rd, er);
        apb(1'b1, 8'h10, 5, rd, er);
        for (int r = 0; r < 2; r++)
        begin
            apb(1'b1, 8'h0C, r, rd, er);
            m.send(3'(2 + r), 0);
            nr = 0;
            for (int t = 0; t < 400 && seq_error !== 1'b1; t++)
            begin
                @(posedge pclk);
                nr += (retry_req === 1'b1);
            end
            ck("retries", r, nr);
            ck("error station", 2 + r, seq_error_station);
            apb(1'b0, 8'(8'h48 + 4 * r), 0, rd, er);
            ck("error count", 1, rd);
            apb(1'b0, 8'h24, 0, rd, er);
            ck("error code", (2 + r) << 8 | 1, rd);
        end
        apb(1'b0, 8'h20, 0, rd, er);
        ck("abnormal flags", 32'h0000000C, rd);
        apb(1'b1, 8'h20, 32'h00000004, rd, er);
        apb(1'b0, 8'h20, 0, rd, er);
        ck("abnormal cleared", 32'h00000008, rd);
        // Reset in mid-run clears counters and restores settings
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 8'h48, 0, rd, er);
        ck("count after reset", 0, rd);
        apb(1'b0, 8'h0C, 0, rd, er);
        ck("retry after reset", 3, rd);
        // Slave station sees a silent peer
        apb(1'b1, 8'h00, 1, rd, er);
        apb(1'b1, 8'h0C, 0, rd, er);
        m.send(3'h4, 0);
        for (int t = 0; t < 400 && seq_error !== 1'b1; t++)
            @(posedge pclk);
        ck("slave error station", 4, seq_error_station);
        apb(1'b0, 8'h24, 0, rd, er);
        ck("slave error code", 32'h00000411, rd);
        m.send(3'h5, 20);
        nr = 0;
        repeat (130)
        begin
            @(posedge pclk);
            nr += (retry_req === 1'b1 || seq_error === 1'b1);
        end
        ck("answered station", 0, nr);
        end_of_test();
    end
    // Watchdog
    initial
    begin
        #100000;
        n_errors++;
        end_of_test();
    end
endmodule // tb
